// File: include/bmf_pkg.sv
// package: constants, carrier types and helpers of the bus matching fifo
package bmf_pkg;

  // ****************************************
  // sizes
  // ****************************************
  localparam int DATA_W = 36;
  localparam int DEPTH = 64;
  localparam int PTR_W = 6;
  localparam int OFS_W = 6;
  localparam logic [PTR_W:0] DEPTH_CNT = 7'h40;
  localparam logic [PTR_W:0] HALF_CNT = 7'h20;
  localparam logic [PTR_W:0] PTR_ONE = 7'h01;

  // default offset pairs, indexed by {load, sel_hi, sel_lo}
  localparam logic [OFS_W-1:0] BMF_DEF_OFS [0:7] = '{
    6'h01, 6'h03, 6'h05, 6'h07, 6'h09, 6'h0B, 6'h0D, 6'h0F};

  // ****************************************
  // types
  // ****************************************
  // code equals index of the last narrow part of a wide word
  typedef enum logic [1:0] {
    BMF_W36 = 2'h0,
    BMF_W18 = 2'h1,
    BMF_W9  = 2'h3
  } bmf_width_type;

  typedef struct packed {
    logic write_clk, write_strobe, write_en_n, write_port_strobed;
    logic read_clk, read_strobe, read_en_n, read_port_strobed;
    logic offset_load_n, serial_load_enable_n, fall_through_or_serial_input;
    logic full_reset_n, partial_reset_n, replay_request_n, output_enable_n;
    logic bus_match_select, input_width_select, output_width_select;
    logic default_offset_sel_lo, default_offset_sel_hi;
    logic flag_timing_select, replay_latency_select;
    logic byte_order_select, parity_position_select;
    logic [DATA_W-1:0] data;
  } bmf_pins_type;

  typedef struct packed {
    bmf_width_type wr_width;
    bmf_width_type rd_width;
    logic fall_through, sync_flags, zero_latency, little_endian, interspersed;
  } bmf_cfg_type;

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [1:0] bmf_last_part(bmf_width_type w);
    return 2'(w);
  endfunction

  // lane 0 is the least significant part
  function automatic logic [1:0] bmf_lane(bmf_width_type w, logic [1:0] idx, logic little);
    return little ? idx : bmf_last_part(w) - idx;
  endfunction

  function automatic logic [DATA_W-1:0] bmf_extract(logic [DATA_W-1:0] word,
                                                     bmf_width_type w, logic [1:0] lane);
    logic [DATA_W-1:0] r;
    r = word;
    if (w == BMF_W18) r = 36'(word[18*lane[0] +: 18]);
    if (w == BMF_W9) r = 36'(word[9*lane +: 9]);
    return r;
  endfunction

  function automatic logic [DATA_W-1:0] bmf_insert(logic [DATA_W-1:0] acc,
      logic [DATA_W-1:0] d, bmf_width_type w, logic [1:0] lane);
    logic [DATA_W-1:0] r;
    r = d;
    if (w == BMF_W18) begin
      r = acc;
      r[18*lane[0] +: 18] = d[17:0];
    end
    if (w == BMF_W9) begin
      r = acc;
      r[9*lane +: 9] = d[8:0];
    end
    return r;
  endfunction

  function automatic logic [OFS_W-1:0] bmf_strip_parity(logic [DATA_W-1:0] d, logic ip);
    logic [31:0] v;
    v = ip ? {d[34:27], d[25:18], d[16:9], d[7:0]} : d[31:0];
    return v[OFS_W-1:0];
  endfunction

endpackage

// File: verification/bmf_agent.sv
// writer and reader pin model facing the bus matching fifo
module bmf_agent
  import bmf_pkg::*;
(
  input  wire logic   clk_in,
  output bmf_pins_type pins_out
);
  timeunit 1ns;
  timeprecision 100ps;
  bmf_pins_type p;
  assign pins_out = p;
  initial begin
    p = '0;
    {p.write_en_n, p.read_en_n, p.offset_load_n, p.serial_load_enable_n} = 4'hF;
    {p.partial_reset_n, p.replay_request_n} = 2'h3;
  end
  // ********************
  // pin cycles
  // ********************
  // straps {bm,iw,ow,ft,ld,hi,lo,pfm,rm,be,ip}, held past release
  task automatic full_rst(input logic [10:0] s);
    @(negedge clk_in);
    {p.bus_match_select, p.input_width_select, p.output_width_select,
     p.fall_through_or_serial_input, p.offset_load_n, p.default_offset_sel_hi,
     p.default_offset_sel_lo, p.flag_timing_select, p.replay_latency_select,
     p.byte_order_select, p.parity_position_select} = s;
    p.full_reset_n = 1'h0;
    repeat (5) @(negedge clk_in);
    p.full_reset_n = 1'h1;
    repeat (4) @(negedge clk_in);
    p.offset_load_n = 1'h1;
  endtask
  // port kinds and output enable {wr strobed, rd strobed, oe_n}
  task automatic set_port(input logic [2:0] s);
    @(negedge clk_in);
    {p.write_port_strobed, p.read_port_strobed, p.output_enable_n} = s;
  endtask
  task automatic part_rst();
    @(negedge clk_in);
    p.partial_reset_n = 1'h0;
    repeat (5) @(negedge clk_in);
    p.partial_reset_n = 1'h1;
    repeat (4) @(negedge clk_in);
  endtask
  // link clock only runs inside a cycle; edges kept off clk_in edges
  task automatic wr(input logic [35:0] d, input logic ld_n, input logic sen_n);
    @(negedge clk_in);
    {p.data, p.write_en_n, p.offset_load_n, p.serial_load_enable_n} = {d, 1'h0, ld_n, sen_n};
    p.fall_through_or_serial_input = d[0];
    // strobe follows the clock so one cycle serves either port kind
    #61.5 {p.write_clk, p.write_strobe} = 2'h3;
    #62.5 {p.write_clk, p.write_strobe} = 2'h0;
    @(negedge clk_in);
    // released bus shows the inverse so stale data cannot pass
    {p.data, p.write_en_n, p.offset_load_n, p.serial_load_enable_n} = {~d, 3'h7};
  endtask
  task automatic rd(input logic en_n, input logic ld_n, input logic rt_n);
    @(negedge clk_in);
    {p.read_en_n, p.offset_load_n, p.replay_request_n} = {en_n, ld_n, rt_n};
    #61.5 {p.read_clk, p.read_strobe} = 2'h3;
    #62.5 {p.read_clk, p.read_strobe} = 2'h0;
    @(negedge clk_in);
    {p.read_en_n, p.offset_load_n, p.replay_request_n} = 3'h7;
  endtask
endmodule

// File: verification/bmf_fifo_tb.sv
// self-checking bench of the bus matching fifo
module bmf_fifo_tb
  import bmf_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic         clk = 1'h0;
  logic         arst_n = 1'h0;
  int           errors = 0;
  int           total_checks = 0;
  bmf_pins_type p;
  logic [35:0]  q;
  logic         oe, ef_n, ff_n, hf_n, ae_n, af_n;
  bmf_agent bmf_agent_inst (.clk_in(clk), .pins_out(p));
  bmf_fifo bmf_fifo_inst (
    .clk_in(clk), .arst_n_in(arst_n), .write_clk_in(p.write_clk),
    .write_strobe_in(p.write_strobe), .write_en_n_in(p.write_en_n),
    .write_port_strobed_in(p.write_port_strobed), .data_in(p.data),
    .offset_load_n_in(p.offset_load_n), .serial_load_enable_n_in(p.serial_load_enable_n),
    .fall_through_or_serial_input_in(p.fall_through_or_serial_input),
    .read_clk_in(p.read_clk), .read_strobe_in(p.read_strobe), .read_en_n_in(p.read_en_n),
    .read_port_strobed_in(p.read_port_strobed), .output_enable_n_in(p.output_enable_n),
    .replay_request_n_in(p.replay_request_n), .full_reset_n_in(p.full_reset_n),
    .partial_reset_n_in(p.partial_reset_n), .bus_match_select_in(p.bus_match_select),
    .input_width_select_in(p.input_width_select),
    .output_width_select_in(p.output_width_select),
    .default_offset_sel_lo_in(p.default_offset_sel_lo),
    .default_offset_sel_hi_in(p.default_offset_sel_hi),
    .flag_timing_select_in(p.flag_timing_select),
    .replay_latency_select_in(p.replay_latency_select),
    .byte_order_select_in(p.byte_order_select),
    .parity_position_select_in(p.parity_position_select), .data_out(q), .data_oe_out(oe),
    .empty_flag_out_valid_n_out(ef_n), .full_flag_in_room_n_out(ff_n),
    .half_full_flag_n_out(hf_n), .almost_empty_flag_n_out(ae_n),
    .almost_full_flag_n_out(af_n));
  initial forever #5 clk = ~clk;
  // ********************
  // compare and finish
  // ********************
  task automatic chk_data(input logic [35:0] got, input logic [35:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: data %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_flags(input logic [4:0] exp);
    total_checks++;
    if ({ef_n, ff_n, hf_n, ae_n, af_n} !== exp) begin
      errors++;
      $display("mismatch at %0t: flags %b expected %b", $time, {ef_n, ff_n, hf_n, ae_n, af_n}, exp);
    end
  endtask
  // standard mode, default offset 9 on both thresholds
  function automatic logic [4:0] exp_flags(input int n);
    return {n != 0, n < 64, n <= 32, n > 9, n < 55};
  endfunction
  task automatic conclude();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // ********************
  // scenarios
  // ********************
  task automatic t_fill();
    bmf_agent_inst.full_rst(11'h044);
    chk_flags(5'h0D);
    for (int i = 1; i <= 65; i++) begin
      bmf_agent_inst.wr({28'hA5A5A5A, 8'(i)}, 1'h1, 1'h1);
      chk_flags(exp_flags(i > 64 ? 64 : i));
      if (i == 1) chk_data(q, 36'h0);
    end
    // the refused write must not overwrite anything
    for (int i = 1; i <= 64; i++) begin
      bmf_agent_inst.rd(1'h0, 1'h1, 1'h1);
      chk_data(q, {28'hA5A5A5A, 8'(i)});
      chk_flags(exp_flags(64 - i));
    end
  endtask
  task automatic t_replay();
    bmf_agent_inst.full_rst(11'h040);
    bmf_agent_inst.set_port(3'h6);
    for (int i = 1; i <= 3; i++) bmf_agent_inst.wr(36'(i * 7), 1'h1, 1'h1);
    chk_data(36'(oe), 36'h1);
    repeat (2) bmf_agent_inst.rd(1'h0, 1'h1, 1'h1);
    chk_data(q, 36'hE);
    bmf_agent_inst.rd(1'h1, 1'h1, 1'h0);
    chk_data(q, 36'h7);
    bmf_agent_inst.set_port(3'h1);
    bmf_agent_inst.rd(1'h0, 1'h1, 1'h1);
    chk_data(q, 36'hE);
    chk_data(36'(oe), 36'h0);
  endtask
  task automatic t_ft();
    bmf_agent_inst.full_rst(11'h0C4);
    bmf_agent_inst.wr(36'h1_2345_6789, 1'h1, 1'h1);
    bmf_agent_inst.wr(36'h9_8765_4321, 1'h1, 1'h1);
    bmf_agent_inst.rd(1'h1, 1'h1, 1'h1);
    chk_flags(5'h15);
    bmf_agent_inst.rd(1'h1, 1'h1, 1'h1);
    chk_flags(5'h05);
    chk_data(q, 36'h1_2345_6789);
    bmf_agent_inst.rd(1'h1, 1'h1, 1'h1);
    chk_data(q, 36'h1_2345_6789);
    bmf_agent_inst.rd(1'h0, 1'h1, 1'h1);
    chk_data(q, 36'h9_8765_4321);
  endtask
  task automatic t_bm();
    int          wd;
    int          sh;
    logic [35:0] w;
    w = 36'hC_3A5F_0E97;
    // m[2] narrow writes into wide reads, else wide writes into narrow reads
    for (int m = 0; m < 8; m++) begin
      wd = m[1] ? 9 : 18;
      bmf_agent_inst.full_rst({1'h1, m[2], m[1], 6'h11, m[0], 1'h0});
      if (!m[2]) bmf_agent_inst.wr(w, 1'h1, 1'h1);
      for (int k = 0; k < 36 / wd; k++) begin
        sh = m[0] ? k : 36 / wd - 1 - k;
        if (m[2]) begin
          bmf_agent_inst.wr((w >> (wd * sh)) & ((36'h1 << wd) - 36'h1), 1'h1, 1'h1);
        end else begin
          bmf_agent_inst.rd(1'h0, 1'h1, 1'h1);
          chk_data(q, (w >> (wd * sh)) & ((36'h1 << wd) - 36'h1));
        end
      end
      if (m[2]) begin
        bmf_agent_inst.rd(1'h0, 1'h1, 1'h1);
        chk_data(q, w);
      end
    end
  endtask
  task automatic rd_ofs(input logic [5:0] e, input logic [5:0] f);
    bmf_agent_inst.rd(1'h0, 1'h0, 1'h1);
    chk_data(36'(q[5:0]), 36'(e));
    bmf_agent_inst.rd(1'h0, 1'h0, 1'h1);
    chk_data(36'(q[5:0]), 36'(f));
  endtask
  task automatic t_ofs();
    // synced threshold flags: almost empty waits for a read event
    bmf_agent_inst.full_rst(11'h04C);
    for (int i = 11; i >= 0; i--) bmf_agent_inst.wr(36'((12'h2C5 >> i) & 12'h1), 1'h0, 1'h0);
    rd_ofs(6'h0B, 6'h05);
    bmf_agent_inst.wr(36'hF_0000_0001, 1'h0, 1'h1);
    bmf_agent_inst.wr(36'h0_0000_0013, 1'h0, 1'h1);
    rd_ofs(6'h01, 6'h13);
    repeat (2) bmf_agent_inst.wr(36'h5, 1'h1, 1'h1);
    chk_flags(5'h1D);
    bmf_agent_inst.part_rst();
    chk_flags(5'h0D);
    repeat (2) bmf_agent_inst.wr(36'h6, 1'h1, 1'h1);
    chk_flags(5'h1D);
    rd_ofs(6'h01, 6'h13);
    chk_flags(5'h1F);
  endtask
  initial begin
    repeat (3) @(posedge clk);
    @(negedge clk);
    arst_n = 1'h1;
    t_fill();
    t_replay();
    t_ft();
    t_bm();
    t_ofs();
    conclude();
  end
  // whole run needs about 30 us
  initial begin
    #300us;
    errors++;
    conclude();
  end
endmodule

// File: verilog/bmf_fifo.sv
// module: bus matching fifo with sampled write and read ports

// How it works
// - widths latched from strap pins at full reset
// - clocked write stores data when enable low
// - strobed write stores data on strobe rise
// - clocked read presents next word when enabled
// - strobed read takes word on strobe rise
// - standard mode: output changes only on read or replay
// - fall-through: first word after three transitions
// - fall-through: later words need read enable
// - timing mode latched at full reset
// - mode picks empty/full or ready flag meaning
// - default offsets chosen by three pins
// - serial offset shift on write clock
// - parallel offset load from data inputs
// - offsets read back on data outputs
// - full reset clears pointers, latches mode
// - partial reset clears pointers, keeps settings
// - unsynced threshold flags follow both clocks
// - synced threshold flags follow own clock
// - replay request rewinds read pointer
// - zero latency replay loads output at once
// - byte order chooses which part first
// - parity bits skipped in parallel offset load
// - byte order latched at full reset
// - parity position latched at full reset
// - half flag compares fill against half
module bmf_fifo
  import bmf_pkg::*;
(
  // clock and reset
  input  wire logic              clk_in,
  input  wire logic              arst_n_in,
  // write port
  input  wire logic              write_clk_in,
  input  wire logic              write_strobe_in,
  input  wire logic              write_en_n_in,
  input  wire logic              write_port_strobed_in,
  input  wire logic [DATA_W-1:0] data_in,
  input  wire logic              offset_load_n_in,
  input  wire logic              serial_load_enable_n_in,
  input  wire logic              fall_through_or_serial_input_in,
  // read port
  input  wire logic              read_clk_in,
  input  wire logic              read_strobe_in,
  input  wire logic              read_en_n_in,
  input  wire logic              read_port_strobed_in,
  input  wire logic              output_enable_n_in,
  input  wire logic              replay_request_n_in,
  // resets and straps
  input  wire logic              full_reset_n_in,
  input  wire logic              partial_reset_n_in,
  input  wire logic              bus_match_select_in,
  input  wire logic              input_width_select_in,
  input  wire logic              output_width_select_in,
  input  wire logic              default_offset_sel_lo_in,
  input  wire logic              default_offset_sel_hi_in,
  input  wire logic              flag_timing_select_in,
  input  wire logic              replay_latency_select_in,
  input  wire logic              byte_order_select_in,
  input  wire logic              parity_position_select_in,
  // data out and flags
  output logic [DATA_W-1:0]      data_out,
  output logic                   data_oe_out,
  output logic                   empty_flag_out_valid_n_out,
  output logic                   full_flag_in_room_n_out,
  output logic                   half_full_flag_n_out,
  output logic                   almost_empty_flag_n_out,
  output logic                   almost_full_flag_n_out
);

  // ****************************************
  // pin synchroniser
  // ****************************************
  bmf_pins_type pins_raw;
  bmf_pins_type sync_a;
  bmf_pins_type pin;
  bmf_pins_type pin_q;

  assign pins_raw = {write_clk_in, write_strobe_in, write_en_n_in, write_port_strobed_in,
                     read_clk_in, read_strobe_in, read_en_n_in, read_port_strobed_in,
                     offset_load_n_in, serial_load_enable_n_in,
                     fall_through_or_serial_input_in,
                     full_reset_n_in, partial_reset_n_in, replay_request_n_in,
                     output_enable_n_in, bus_match_select_in, input_width_select_in,
                     output_width_select_in, default_offset_sel_lo_in,
                     default_offset_sel_hi_in, flag_timing_select_in,
                     replay_latency_select_in, byte_order_select_in,
                     parity_position_select_in, data_in};

  // data is synchronised with its edges so both lag alike
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sync_a <= '0;
      pin <= '0;
      pin_q <= '0;
    end else begin
      sync_a <= pins_raw;
      pin <= sync_a;
      pin_q <= pin;
    end
  end

  // ****************************************
  // events
  // ****************************************
  logic wclk_rise;
  logic rclk_rise;
  logic rclk_turn;
  logic wr_edge;
  logic rd_edge;
  logic wr_tick;
  logic rd_tick;
  logic full_rst;
  logic part_rst;
  logic any_rst;
  logic rd_req;
  logic replay;
  logic wr_data;
  logic par_load;
  logic ser_load;
  logic ofs_read;
  logic data_read;

  assign wclk_rise = pin.write_clk & ~pin_q.write_clk;
  assign rclk_rise = pin.read_clk & ~pin_q.read_clk;
  assign rclk_turn = pin.read_clk ^ pin_q.read_clk;
  assign wr_edge = pin.write_port_strobed ? pin.write_strobe & ~pin_q.write_strobe
                                          : wclk_rise;
  assign rd_edge = pin.read_port_strobed ? pin.read_strobe & ~pin_q.read_strobe
                                         : rclk_rise;
  assign wr_tick = wr_edge | wclk_rise;
  assign rd_tick = rd_edge | rclk_turn;
  assign full_rst = ~pin.full_reset_n;
  assign part_rst = ~pin.partial_reset_n;
  assign any_rst = full_rst | part_rst;
  assign rd_req = rd_edge & ~pin.read_en_n & ~any_rst;
  assign replay = rclk_rise & ~pin.replay_request_n & ~any_rst;
  assign wr_data = wr_edge & ~pin.write_en_n & pin.offset_load_n & ~any_rst;
  assign par_load = wclk_rise & ~pin.write_en_n & ~pin.offset_load_n & ~any_rst;
  assign ser_load = wclk_rise & ~pin.serial_load_enable_n & ~pin.offset_load_n
                  & ~any_rst;
  assign ofs_read = rd_req & ~pin.offset_load_n;
  assign data_read = rd_req & pin.offset_load_n & ~replay;

  // ****************************************
  // configuration straps
  // ****************************************
  bmf_width_type wr_w;
  bmf_width_type rd_w;
  bmf_cfg_type   strap_cfg;
  bmf_cfg_type   cfg;

  assign wr_w = (pin.bus_match_select & pin.input_width_select)
              ? (pin.output_width_select ? BMF_W9 : BMF_W18) : BMF_W36;
  assign rd_w = (pin.bus_match_select & ~pin.input_width_select)
              ? (pin.output_width_select ? BMF_W9 : BMF_W18) : BMF_W36;
  assign strap_cfg = {wr_w, rd_w,
                      pin.fall_through_or_serial_input,
                      pin.flag_timing_select,
                      ~pin.replay_latency_select,
                      pin.byte_order_select,
                      pin.parity_position_select};

  // straps follow the pins for the whole full reset, frozen at release
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) cfg <= '0;
    else if (full_rst) cfg <= strap_cfg;
  end

  // ****************************************
  // write side and storage
  // ****************************************
  logic [DATA_W-1:0] mem [0:DEPTH-1];
  logic [PTR_W:0]    wptr;
  logic [PTR_W:0]    next_wptr;
  logic [PTR_W:0]    rptr;
  logic [PTR_W:0]    next_rptr;
  logic [PTR_W:0]    count;
  logic [PTR_W:0]    next_count;
  logic [1:0]        wsub;
  logic [DATA_W-1:0] wacc;
  logic [DATA_W-1:0] merged;
  logic              w_last;
  logic              full_now;
  logic              w_take;
  logic              commit;

  assign merged = bmf_insert(wacc, pin.data, cfg.wr_width,
                             bmf_lane(cfg.wr_width, wsub, cfg.little_endian));
  assign w_last = wsub == bmf_last_part(cfg.wr_width);
  assign count = wptr - rptr;
  assign full_now = count == DEPTH_CNT;
  // a write into a full store is dropped, not queued
  assign w_take = wr_data & ~full_now;
  assign commit = w_take & w_last;
  assign next_wptr = any_rst ? '0 : commit ? wptr + PTR_ONE : wptr;

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wptr <= '0;
      wsub <= 2'h0;
      wacc <= '0;
    end else begin
      wptr <= next_wptr;
      if (any_rst) wsub <= 2'h0;
      else if (w_take) wsub <= w_last ? 2'h0 : wsub + 2'h1;
      if (w_take) wacc <= merged;
    end
  end

  always_ff @(posedge clk_in) begin
    if (commit) mem[wptr[PTR_W-1:0]] <= merged;
  end

  // ****************************************
  // read side
  // ****************************************
  logic [PTR_W:0]    base_ptr;
  logic [1:0]        base_sub;
  logic [1:0]        rsub;
  logic [1:0]        next_rsub;
  logic [1:0]        ft_cnt;
  logic              avail;
  logic              r_last;
  logic              ft_load;
  logic              pop;
  logic              out_valid;
  logic              next_valid;
  logic              rd_sel;
  logic [DATA_W-1:0] pop_word;
  logic [DATA_W-1:0] ofs_word;
  logic [OFS_W-1:0]  ae_off;
  logic [OFS_W-1:0]  af_off;

  assign base_ptr = replay ? '0 : rptr;
  assign base_sub = replay ? 2'h0 : rsub;
  assign avail = base_ptr != wptr;
  assign r_last = base_sub == bmf_last_part(cfg.rd_width);
  // third read clock transition with data waiting and nothing shown
  assign ft_load = cfg.fall_through & ~out_valid & avail & rclk_turn & (ft_cnt == 2'h2)
                 & ~replay & ~any_rst;
  assign pop = avail & ~any_rst
             & (data_read | ft_load | (replay & cfg.zero_latency));
  assign next_rsub = any_rst ? 2'h0 : pop ? (r_last ? 2'h0 : base_sub + 2'h1) : base_sub;
  assign next_rptr = any_rst ? '0 : (pop & r_last) ? base_ptr + PTR_ONE : base_ptr;
  assign next_count = next_wptr - next_rptr;
  assign pop_word = bmf_extract(mem[base_ptr[PTR_W-1:0]], cfg.rd_width,
                                bmf_lane(cfg.rd_width, base_sub, cfg.little_endian));
  assign ofs_word = 36'(rd_sel ? af_off : ae_off);
  assign next_valid = any_rst ? 1'b0 : pop ? 1'b1
                    : (cfg.fall_through & (data_read | replay)) ? 1'b0 : out_valid;

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rptr <= '0;
      rsub <= 2'h0;
      out_valid <= 1'b0;
    end else begin
      rptr <= next_rptr;
      rsub <= next_rsub;
      out_valid <= next_valid;
    end
  end

  // transition counter only runs while a word waits to fall through
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) ft_cnt <= 2'h0;
    else if (any_rst | out_valid | ~avail | ~cfg.fall_through) ft_cnt <= 2'h0;
    else if (rclk_turn & ft_cnt != 2'h2) ft_cnt <= ft_cnt + 2'h1;
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) data_out <= '0;
    else if (ofs_read) data_out <= ofs_word;
    else if (pop) data_out <= pop_word;
  end

  // no tristate here: the enable goes out, the pad resolves it
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) data_oe_out <= 1'b0;
    else data_oe_out <= ~pin.output_enable_n;
  end

  // ****************************************
  // offset registers
  // ****************************************
  logic [2:0]       def_idx;
  logic [OFS_W-1:0] par_val;
  logic             par_sel;

  assign def_idx = {pin.offset_load_n, pin.default_offset_sel_hi, pin.default_offset_sel_lo};
  assign par_val = bmf_strip_parity(pin.data, cfg.interspersed);

  // partial reset leaves offsets and load order alone
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ae_off <= '0;
      af_off <= '0;
      par_sel <= 1'b0;
      rd_sel <= 1'b0;
    end else if (full_rst) begin
      ae_off <= BMF_DEF_OFS[def_idx];
      af_off <= BMF_DEF_OFS[def_idx];
      par_sel <= 1'b0;
      rd_sel <= 1'b0;
    end else begin
      if (ser_load) begin
        {ae_off, af_off} <= {ae_off[OFS_W-2:0], af_off,
                             pin.fall_through_or_serial_input};
      end else if (par_load) begin
        par_sel <= ~par_sel;
        if (par_sel) af_off <= par_val;
        else ae_off <= par_val;
      end
      if (ofs_read) rd_sel <= ~rd_sel;
    end
  end

  // ****************************************
  // status flags
  // ****************************************
  logic ae_upd;
  logic af_upd;

  assign ae_upd = any_rst | rd_tick | (~cfg.sync_flags & wr_tick);
  assign af_upd = any_rst | wr_tick | (~cfg.sync_flags & rd_tick);

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      empty_flag_out_valid_n_out <= 1'b0;
      full_flag_in_room_n_out <= 1'b1;
      half_full_flag_n_out <= 1'b1;
    end else begin
      empty_flag_out_valid_n_out <= cfg.fall_through ? ~next_valid
                                                     : next_count != '0;
      full_flag_in_room_n_out <= cfg.fall_through ? next_count == DEPTH_CNT
                                                  : next_count != DEPTH_CNT;
      half_full_flag_n_out <= next_count <= HALF_CNT;
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      almost_empty_flag_n_out <= 1'b0;
      almost_full_flag_n_out <= 1'b1;
    end else begin
      if (ae_upd) almost_empty_flag_n_out <= next_count > {1'b0, ae_off};
      if (af_upd) almost_full_flag_n_out <= next_count < DEPTH_CNT - {1'b0, af_off};
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);

  AST_WIDTH_LATCH: assert property (full_rst |=> cfg == $past(strap_cfg))
    else $error("straps not latched at full reset");
  AST_WR_STORE: assert property (commit |=> wptr == $past(wptr) + PTR_ONE)
    else $error("complete write word not stored");
  AST_PACK: assert property (w_take && !w_last |=> wptr == $past(wptr)
                             && wsub == $past(wsub) + 2'h1)
    else $error("narrow write part lost or stored early");
  AST_STD_HOLD: assert property (!cfg.fall_through && !rd_req && !replay
                                 |=> $stable(data_out))
    else $error("standard mode output moved without a read");
  AST_FT_FALL: assert property (ft_load |=> !empty_flag_out_valid_n_out
                                && data_out == $past(pop_word))
    else $error("fall-through word not presented");
  AST_FT_KEEP: assert property (cfg.fall_through && out_valid && !rd_req && !replay
                                && !any_rst |=> out_valid [*1])
    else $error("fall-through word dropped without read enable");
  AST_FULL_RST: assert property (full_rst |=> wptr == '0 && rptr == '0)
    else $error("full reset left pointers set");
  AST_PART_RST: assert property (part_rst && !full_rst |=> wptr == '0
                                 && $stable(ae_off) && $stable(af_off)
                                 && $stable(cfg))
    else $error("partial reset changed settings");
  AST_REPLAY: assert property (replay && !(cfg.zero_latency && avail)
                               |=> rptr == '0 && rsub == 2'h0)
    else $error("replay did not rewind");
  AST_ZERO_LAT: assert property (replay && cfg.zero_latency && avail && !ofs_read
                                 |=> data_out == $past(pop_word) && out_valid)
    else $error("zero latency replay did not load output");
  AST_SERIAL: assert property (ser_load |=> af_off[0]
                               == $past(pin.fall_through_or_serial_input))
    else $error("serial bit not shifted in");
  AST_HALF: assert property (half_full_flag_n_out == (count <= HALF_CNT))
    else $error("half flag disagrees with fill");
  AST_PAF_SYNC: assert property (cfg.sync_flags && !wr_tick && !any_rst
                                 |=> $stable(almost_full_flag_n_out))
    else $error("synced almost full moved off its clock");

  COV_NARROW_READ: cover property (pop && cfg.rd_width == BMF_W9 && r_last);
  COV_FULL: cover property (full_now ##1 !full_now);
  COV_FT_LOAD: cover property (ft_load);
  COV_REPLAY_ZERO: cover property (replay && cfg.zero_latency && avail);

endmodule
